// ==== rtl/dcr_pkg.sv ====
// Purpose: constants and types for the clear-code and reset-cause register slice
// Assumes: AXI4-Lite slave, 32-bit data, index offsets times four
// Notes: flag positions follow the figure, bits 3:0
// Operation
// R1 - broadcast write copies code bits 15:4
// R2 - only broadcast-enabled channels take the code
// R3 - broadcast register at Eh, low nibble zero
// R4 - flag register at Fh resets to 000Fh
// R5 - supply collapse event sets its flag
// R6 - reset pin event sets its flag
// R7 - io supply reset sets its flag
// R8 - main supply por sets its flag
// R9 - channel 0 code at 10h, read-write
// R10 - channel 1 code at 11h, read-write
// R11 - channel 2 code at 12h, read-write
// R12 - cleared channel drives its clear code
// R13 - flags stick until software writes zero
package dcr_pkg;
  localparam int          NCH            = 3;
  localparam logic [7:0]  IDX_BCAST      = 8'h0E;
  localparam logic [7:0]  IDX_FLAGS      = 8'h0F;
  localparam logic [7:0]  IDX_CH0        = 8'h10;
  localparam logic [7:0]  IDX_CH1        = 8'h11;
  localparam logic [7:0]  IDX_CH2        = 8'h12;
  localparam logic [7:0]  IDX_CTRL       = 8'h20;
  localparam logic [7:0]  IDX_IRQ_STAT   = 8'h21;
  localparam logic [7:0]  IDX_IRQ_MASK   = 8'h22;
  localparam int          CODE_LSB       = 4;
  localparam logic [15:0] RST_CODE       = 16'h0000;
  localparam logic [3:0]  RST_FLAGS      = 4'hF;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam int          FLAG_COLLAPSE  = 3;
  localparam int          FLAG_PIN       = 2;
  localparam int          FLAG_IO        = 1;
  localparam int          FLAG_POR       = 0;

  typedef struct packed {
    logic [NCH-1:0] bcast_en;
    logic [NCH-1:0] soft_clear;
  } dcr_ctrl_type;
endpackage

// ==== rtl/dcr_regs.sv ====
// Purpose: register slice holding clear codes, buffer codes and reset-cause flags
// Assumes: event inputs come from other clock or analog domains, synchronised here
// Notes: unmapped addresses answer SLVERR and read zero
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
module dcr_regs
  import dcr_pkg::*;
(
  input  wire logic              clk,            // 50 MHz clock
  input  wire logic              srst,           // sync reset, active high
  input  wire logic [7:0]        s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // write strobes
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // write response valid
  input  wire logic              s_axi_bready,   // write response ready
  input  wire logic [7:0]        s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  input  wire logic              evt_collapse,   // supply collapse event
  input  wire logic              evt_pin_reset,  // reset pin event
  input  wire logic              evt_io_reset,   // io supply reset event
  input  wire logic              evt_por,        // main supply por event
  output logic [NCH*12-1:0]      channel_code,   // code driven per channel
  output logic                   irq             // level interrupt
);

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] word_index(input logic [7:0] a);
    return {2'h0, a[7:2]};
  endfunction

  logic [3:0]        ev_s1;
  logic [3:0]        ev_s2;
  logic [3:0]        ev_d;
  logic [11:0]       bcast_code;
  logic [11:0]       clear_code [NCH];
  logic [11:0]       buf_code   [NCH];
  logic [3:0]        flags;
  logic [3:0]        irq_stat;
  logic [3:0]        irq_mask;
  dcr_ctrl_type      ctrl;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_idx;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  wire [3:0] ev_rise = ev_s2 & ~ev_d;
  wire       do_wr   = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_lo   = w_strb[0];
  wire       wr_hi   = w_strb[1];
  wire       do_rd   = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_idx  = word_index(s_axi_araddr);
  wire       wr_bc   = do_wr & (aw_idx == IDX_BCAST);
  wire       wr_fl   = do_wr & (aw_idx == IDX_FLAGS) & wr_lo;
  wire       wr_ct   = do_wr & (aw_idx == IDX_CTRL) & wr_lo;
  wire       wr_mk   = do_wr & (aw_idx == IDX_IRQ_MASK) & wr_lo;
  wire       rd_st   = do_rd & (rd_idx == IDX_IRQ_STAT);
  wire [11:0] w_code = {wr_hi ? w_data[15:8] : 8'h00, wr_lo ? w_data[7:4] : 4'h0};
  wire       wr_map  = (aw_idx == IDX_BCAST) | (aw_idx == IDX_FLAGS)
                     | (aw_idx == IDX_CH0) | (aw_idx == IDX_CH1) | (aw_idx == IDX_CH2)
                     | (aw_idx == IDX_CTRL) | (aw_idx == IDX_IRQ_STAT)
                     | (aw_idx == IDX_IRQ_MASK);

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (rd_idx == IDX_BCAST) begin
      rd_mux = {16'h0000, bcast_code, 4'h0};                   // [R3]
    end else if (rd_idx == IDX_FLAGS) begin
      rd_mux = {28'h0000000, flags};                           // [R4] [R13]
    end else if (rd_idx == IDX_CH0) begin
      rd_mux = {16'h0000, buf_code[0], 4'h0};                  // [R9]
    end else if (rd_idx == IDX_CH1) begin
      rd_mux = {16'h0000, buf_code[1], 4'h0};                  // [R10]
    end else if (rd_idx == IDX_CH2) begin
      rd_mux = {16'h0000, buf_code[2], 4'h0};                  // [R11]
    end else if (rd_idx == IDX_CTRL) begin
      rd_mux = {26'h0000000, ctrl};
    end else if (rd_idx == IDX_IRQ_STAT) begin
      rd_mux = {28'h0000000, irq_stat};
    end else if (rd_idx == IDX_IRQ_MASK) begin
      rd_mux = {28'h0000000, irq_mask};
    end else begin
      rd_hit = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (srst) begin
      ev_s1 <= 4'h0;
      ev_s2 <= 4'h0;
      ev_d  <= 4'h0;
    end else begin
      ev_s1 <= {evt_collapse, evt_pin_reset, evt_io_reset, evt_por};
      ev_s2 <= ev_s1;
      ev_d  <= ev_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi write channel
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= word_index(s_axi_awaddr);
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // axi read channel
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // code registers
  always_ff @(posedge clk) begin
    if (srst) begin
      bcast_code <= RST_CODE[15:4];
      for (int i = 0; i < NCH; i++) begin
        clear_code[i] <= RST_CODE[15:4];
        buf_code[i]   <= RST_CODE[15:4];
      end
    end else begin
      if (wr_bc) begin
        bcast_code <= w_code;                                   // [R3]
      end
      for (int i = 0; i < NCH; i++) begin
        if (wr_bc & ctrl.bcast_en[i]) begin
          clear_code[i] <= w_code;                              // [R1] [R2]
        end
        if (do_wr & (aw_idx == IDX_CH0 + 8'(i))) begin
          buf_code[i] <= w_code;                                // [R9] [R10] [R11]
        end
      end
    end
  end

  // cleared channel drives its clear code
  always_ff @(posedge clk) begin
    if (srst) begin
      channel_code <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        channel_code[i*12 +: 12] <= ctrl.soft_clear[i] ? clear_code[i] : buf_code[i]; // [R12]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flags, control, interrupt; hardware set beats software write
  always_ff @(posedge clk) begin
    if (srst) begin
      flags    <= RST_FLAGS;                                    // [R4]
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      ctrl     <= '0;
      irq      <= 1'b0;
    end else begin
      flags    <= (wr_fl ? (flags & w_data[3:0]) : flags) | ev_rise; // [R5] [R6] [R7] [R8] [R13]
      irq_stat <= (rd_st ? 4'h0 : irq_stat) | ev_rise;
      if (wr_mk) begin
        irq_mask <= w_data[3:0];
      end
      if (wr_ct) begin
        ctrl <= dcr_ctrl_type'(w_data[5:0]);
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_BCAST_LOAD: assert property (@(posedge clk) disable iff (srst)
    wr_bc & ctrl.bcast_en[0] |=> clear_code[0] == $past(w_code)) // [R1]
    else $error("broadcast code not loaded");
  AST_BCAST_SKIP: assert property (@(posedge clk) disable iff (srst)
    wr_bc & ~ctrl.bcast_en[1] |=> $stable(clear_code[1]))          // [R2]
    else $error("disabled channel changed");
  AST_BCAST_LOW: assert property (@(posedge clk) disable iff (srst)
    do_rd & (rd_idx == IDX_BCAST) |=> s_axi_rdata[3:0] == 4'h0)   // [R3]
    else $error("reserved bits nonzero");
  AST_FLAG_RESET: assert property (@(posedge clk)
    srst |=> flags == RST_FLAGS)                                   // [R4]
    else $error("flag reset value wrong");
  AST_COLLAPSE_SET: assert property (@(posedge clk) disable iff (srst)
    ev_rise[FLAG_COLLAPSE] |=> flags[FLAG_COLLAPSE])               // [R5]
    else $error("collapse flag not set");
  AST_PIN_SET: assert property (@(posedge clk) disable iff (srst)
    $rose(ev_s2[FLAG_PIN]) |=> flags[FLAG_PIN])                    // [R6]
    else $error("pin flag not set");
  AST_IO_SET: assert property (@(posedge clk) disable iff (srst)
    ev_rise[FLAG_IO] & wr_fl |=> flags[FLAG_IO])                   // [R7]
    else $error("io flag lost under write");
  AST_POR_SET: assert property (@(posedge clk) disable iff (srst)
    ev_rise[FLAG_POR] |=> flags[FLAG_POR] ##1 (flags[FLAG_POR] | $past(wr_fl))) // [R8]
    else $error("por flag not sticky");
  AST_CH0_WR: assert property (@(posedge clk) disable iff (srst)
    do_wr & (aw_idx == IDX_CH0) |=> buf_code[0] == $past(w_code))  // [R9]
    else $error("channel 0 write lost");
  AST_CH1_WR: assert property (@(posedge clk) disable iff (srst)
    do_wr & (aw_idx == IDX_CH1) |=> buf_code[1] == $past(w_code))  // [R10]
    else $error("channel 1 write lost");
  AST_CH2_WR: assert property (@(posedge clk) disable iff (srst)
    do_wr & (aw_idx == IDX_CH2) |=> buf_code[2] == $past(w_code))  // [R11]
    else $error("channel 2 write lost");
  AST_CLEAR_DRIVE: assert property (@(posedge clk) disable iff (srst)
    ctrl.soft_clear[0] |=> channel_code[11:0] == $past(clear_code[0])) // [R12]
    else $error("cleared channel code wrong");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (srst)
    flags[FLAG_PIN] & ~wr_fl |=> flags[FLAG_PIN])                  // [R13]
    else $error("flag dropped without write");

endmodule

// ==== tb/dcr_evt_src.sv ====
// Purpose: stand-in for the analog event sources seen by the flag logic
// Assumes: fire is a one-cycle request, one bit per event line
// Notes: a line is held high a few cycles, then released low
`timescale 1ns/1ns
module dcr_evt_src (
  input  wire logic       clk,   // bench clock
  input  wire logic       srst,  // sync reset, active high
  input  wire logic [3:0] fire,  // request per event line
  output logic      [3:0] evt    // collapse, pin, io, por
);
  logic [2:0] hold;

  // long enough to pass the two-flop synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      evt  <= 4'h0;
      hold <= 3'h0;
    end else if (fire != 4'h0) begin
      evt  <= fire;
      hold <= 3'h5;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else begin
      evt <= 4'h0;
    end
  end
endmodule

// ==== tb/test_dcr_regs.sv ====
// Purpose: self-checking bench for the clear-code and reset-cause slice
// Assumes: AXI4-Lite master tasks, byte address is index times four
// Notes: events come from the event source model
`timescale 1ns/1ns
module test_dcr_regs
  import dcr_pkg::*;
;
  logic        clk, srst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, fire, evt;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic [35:0] channel_code;
  logic [31:0] rd_data;
  logic [3:0]  exp_flags;
  int          err_total, checked;

  dcr_regs dcr_regs_i (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .evt_collapse(evt[3]),
    .evt_pin_reset(evt[2]), .evt_io_reset(evt[1]), .evt_por(evt[0]),
    .channel_code(channel_code), .irq(irq));
  dcr_evt_src dcr_evt_src_i (.clk(clk), .srst(srst), .fire(fire), .evt(evt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
    s_axi_awaddr  <= {idx[5:0], 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    resp = s_axi_bresp;
  endtask

  task automatic axi_rd(input logic [7:0] idx);
    s_axi_araddr  <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_data = s_axi_rdata;
    resp    = s_axi_rresp;
  endtask

  task automatic pulse_evt(input int i);
    fire <= 4'h1 << i;
    @(posedge clk);
    fire <= 4'h0;
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    err_total = 0;
    checked = 0;
    srst = 1'b1;
    fire = 4'h0;
    s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    axi_rd(IDX_FLAGS);
    check(rd_data, 32'h0000_000F);
    axi_rd(IDX_BCAST);
    check(rd_data, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      axi_rd(IDX_CH0 + 8'(i));
      check(rd_data, 32'h0000_0000);
    end
    // flags armed, each event sets only its own bit
    axi_wr(IDX_IRQ_MASK, 32'h0000_000F);
    axi_wr(IDX_FLAGS, 32'h0000_0000);
    axi_rd(IDX_FLAGS);
    check(rd_data, 32'h0000_0000);
    exp_flags = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      pulse_evt(i);
      exp_flags[i] = 1'b1;
      axi_rd(IDX_FLAGS);
      check(rd_data, {28'h0, exp_flags});
    end
    check(irq, 1'b1);
    axi_rd(IDX_IRQ_STAT);
    check(rd_data, 32'h0000_000F);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    axi_wr(IDX_IRQ_MASK, 32'h0000_0000);
    pulse_evt(FLAG_PIN);
    check(irq, 1'b0);
    // arming write lands on the io event edge: the event wins
    fire <= 4'h1 << FLAG_IO;
    @(posedge clk);
    fire <= 4'h0;
    axi_wr(IDX_FLAGS, 32'h0000_0000);
    repeat (4) @(posedge clk);
    axi_rd(IDX_FLAGS);
    check(rd_data, 32'h0000_0002);
    // buffer codes keep bits 15:4 only
    for (int i = 0; i < 3; i++) begin
      axi_wr(IDX_CH0 + 8'(i), 32'hFFFF_1235 + i * 32'h1111);
      axi_rd(IDX_CH0 + 8'(i));
      check(rd_data, 32'h0000_1230 + i * 32'h1110);
    end
    check(channel_code, {12'h345, 12'h234, 12'h123});
    // broadcast to ch0 and ch2, all in clear state
    axi_wr(IDX_CTRL, 32'h0000_002F);
    axi_wr(IDX_BCAST, 32'h0000_ABCF);
    check(resp, RESP_OKAY);
    axi_rd(IDX_BCAST);
    check(rd_data, 32'h0000_ABC0);
    repeat (2) @(posedge clk);
    check(channel_code, {12'hABC, 12'h000, 12'hABC});
    axi_wr(IDX_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    check(channel_code, {12'h345, 12'h234, 12'h123});
    // unmapped place
    axi_wr(8'h30, 32'h0000_FFFF);
    check(resp, RESP_SLVERR);
    axi_rd(8'h30);
    check({resp, rd_data}, {RESP_SLVERR, 32'h0});
    tally_and_finish();
  end
endmodule
